/* logic/adc_cfg_defs.vh */
// Register offsets, field positions and reset values of the converter configuration bank
// Contract
// - Group B gain code split: upper sixteen bits in one register, lower six in next.
// - Bandwidth bits 9-2, channel eight at top; zero low-noise, one wide-bandwidth.
// - Power-down field: 0 none, 1 ch5-8, 2 ch1-4, 3 all.
// - Reference bit 11: zero internal reference, one external reference.
// - Lane bit 9: zero four lanes D3/D2 and D1/D0; one uses D3 and D1.
// - Rate bit 8: zero double data rate, one single data rate.
// - Four-bit range field per channel, ch1-4 in one register, ch5-8 next.
// - Range codes: 0=5V,1=3.5V,2=2.5V,3=7V,4=10V,5=12V.
// - Common-mode range fields bits 9-8 high group, 7-6 low group.
// - Bits 3 and 2 enable wide common-mode control, high and low groups.
// - Common-mode register bit 0 powers down the entire device.
// - Global bit 4 zero forces twelve-volt common mode; one applies group settings.
`ifndef ADC_CFG_DEFS_VH
`define ADC_CFG_DEFS_VH

// Register indices; byte address is four times the index, with the bank select bit set on top for IDX_BOOST_BANK2
`define IDX_GAIN_UPPER      8'h4a
`define IDX_GAIN_LOWER      8'h4b
`define IDX_INIT_TWO        8'h92
`define IDX_BW_PD           8'hc0
`define IDX_REF_FMT         8'hc1
`define IDX_RANGE_LOW       8'hc2
`define IDX_RANGE_HIGH      8'hc3
`define IDX_CM_PD           8'hc4
`define IDX_INIT_CM         8'hc5
`define IDX_BOOST_BANK2     8'h25

// Bank select bit in the word address (second bank lives above it)
`define BANK_SEL_BIT        8

// Writable masks per register
`define MASK_GAIN_UPPER     16'hffff
`define MASK_GAIN_LOWER     16'h003f
`define MASK_INIT_TWO       16'h0002
`define MASK_BW_PD          16'h03ff
`define MASK_REF_FMT        16'h0b00
`define MASK_RANGE          16'hffff
`define MASK_CM_PD          16'h03ff
`define MASK_INIT_CM        16'hc67c
`define MASK_BOOST_BANK2    16'h0a00

`define RESET_VALUE         16'h0000

// Field positions
`define POS_INIT_TWO        1
`define POS_BW_LSB          2
`define POS_REF_SEL         11
`define POS_LANES           9
`define POS_RATE            8
`define POS_CM_RNG_HI       8
`define POS_CM_RNG_LO       6
`define POS_CM_EN_HI        3
`define POS_CM_EN_LO        2
`define POS_CHIP_PD         0
`define POS_INIT_THREE      10
`define POS_AMP_INIT_SECOND 9
`define POS_CM_GLOBAL       4
`define POS_AMP_INIT_FIRST  2
`define POS_BOOST_C         9
`define POS_BOOST_D         11

// Codes
`define CM_CODE_HALF        2'h0
`define CM_CODE_6V          2'h1
`define CM_CODE_12V         2'h2
`define RANGE_CODE_MAX      4'h5

`endif

/* logic/adc_config_register_bank.v */
// AHB-Lite register bank for the eight-channel converter configuration
`timescale 1ns/1ps
`include "adc_cfg_defs.vh"
module adc_config_register_bank
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [21:0] gain_corr_group_b,
    output reg  [7:0]  channel_bandwidth_select,
    output reg  [7:0]  channel_powered_down,
    output reg         reference_source_select,
    output reg         lanes_two_mode,
    output reg  [1:0]  data_out_lane_enable_hi,
    output reg  [1:0]  data_out_lane_enable_lo,
    output reg         single_data_rate,
    output reg  [31:0] input_range_field,
    output reg  [7:0]  input_range_valid,
    output reg  [1:0]  common_mode_range_low_group,
    output reg  [1:0]  common_mode_range_high_group,
    output reg         common_mode_enable_low_group,
    output reg         common_mode_enable_high_group,
    output reg         full_device_powerdown,
    output reg         init_complete,
    output reg         speed_boost_cfg_c,
    output reg         speed_boost_cfg_d
);
    // Register storage
    reg  [15:0] gain_upper_q;
    reg  [15:0] gain_lower_q;
    reg  [15:0] init_two_q;
    reg  [15:0] bw_pd_q;
    reg  [15:0] ref_fmt_q;
    reg  [15:0] range_low_q;
    reg  [15:0] range_high_q;
    reg  [15:0] cm_pd_q;
    reg  [15:0] init_cm_q;
    reg  [15:0] boost_q;

    // Captured address phase
    reg         wr_pend_q;
    reg  [8:0]  wr_idx_q;

    wire [21:0] gain_joined;
    wire [7:0]  range_ok;

    wire        addr_phase;
    wire [8:0]  addr_idx;
    wire [15:0] wdata16;

    // Word index including bank select bit
    function [8:0] word_index;
        input [31:0] a;
        begin
            word_index = a[10:2];
        end
    endfunction

    // Map an index to its writable mask; zero means unmapped
    function [15:0] reg_mask;
        input [8:0] idx;
        begin
            case (idx)
                {1'b0, `IDX_GAIN_UPPER}:  reg_mask = `MASK_GAIN_UPPER;
                {1'b0, `IDX_GAIN_LOWER}:  reg_mask = `MASK_GAIN_LOWER;
                {1'b0, `IDX_INIT_TWO}:    reg_mask = `MASK_INIT_TWO;
                {1'b0, `IDX_BW_PD}:       reg_mask = `MASK_BW_PD;
                {1'b0, `IDX_REF_FMT}:     reg_mask = `MASK_REF_FMT;
                {1'b0, `IDX_RANGE_LOW}:   reg_mask = `MASK_RANGE;
                {1'b0, `IDX_RANGE_HIGH}:  reg_mask = `MASK_RANGE;
                {1'b0, `IDX_CM_PD}:       reg_mask = `MASK_CM_PD;
                {1'b0, `IDX_INIT_CM}:     reg_mask = `MASK_INIT_CM;
                {1'b1, `IDX_BOOST_BANK2}: reg_mask = `MASK_BOOST_BANK2;
                default:                  reg_mask = 16'h0000;
            endcase
        end
    endfunction

    function [15:0] masked_write;
        input [15:0] old_v;
        input [15:0] new_v;
        input [15:0] m;
        begin
            // Reserved bits keep their reset value whatever the host sends
            masked_write = (old_v & ~m) | (new_v & m);
        end
    endfunction

    assign addr_phase = hsel & hready & htrans[1];
    assign addr_idx   = word_index(haddr);
    assign wdata16    = hwdata[15:0];

    gain_code_join u_join
    (
        .upper       (gain_upper_q),
        .lower       (gain_lower_q),
        .range_lo    (range_low_q),
        .range_hi    (range_high_q),
        .gain_code   (gain_joined),
        .range_valid (range_ok)
    );

    // Zero wait states: always ready, always OKAY
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 9'h000;
            hrdata    <= 32'h0000_0000;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_q <= addr_phase & hwrite;
            if (addr_phase)
                wr_idx_q <= addr_idx;
            // Read data prepared from the address phase; unmapped reads zero
            if (addr_phase && !hwrite)
            begin
                case (addr_idx)
                    {1'b0, `IDX_GAIN_UPPER}:  hrdata <= {16'h0000, gain_upper_q};
                    {1'b0, `IDX_GAIN_LOWER}:  hrdata <= {16'h0000, gain_lower_q};
                    {1'b0, `IDX_INIT_TWO}:    hrdata <= {16'h0000, init_two_q};
                    {1'b0, `IDX_BW_PD}:       hrdata <= {16'h0000, bw_pd_q};
                    {1'b0, `IDX_REF_FMT}:     hrdata <= {16'h0000, ref_fmt_q};
                    {1'b0, `IDX_RANGE_LOW}:   hrdata <= {16'h0000, range_low_q};
                    {1'b0, `IDX_RANGE_HIGH}:  hrdata <= {16'h0000, range_high_q};
                    {1'b0, `IDX_CM_PD}:       hrdata <= {16'h0000, cm_pd_q};
                    {1'b0, `IDX_INIT_CM}:     hrdata <= {16'h0000, init_cm_q};
                    {1'b1, `IDX_BOOST_BANK2}: hrdata <= {16'h0000, boost_q};
                    default:                  hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Data phase write
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            gain_upper_q <= `RESET_VALUE;
            gain_lower_q <= `RESET_VALUE;
            init_two_q   <= `RESET_VALUE;
            bw_pd_q      <= `RESET_VALUE;
            ref_fmt_q    <= `RESET_VALUE;
            range_low_q  <= `RESET_VALUE;
            range_high_q <= `RESET_VALUE;
            cm_pd_q      <= `RESET_VALUE;
            init_cm_q    <= `RESET_VALUE;
            boost_q      <= `RESET_VALUE;
        end
        else if (wr_pend_q)
        begin
            case (wr_idx_q)
                {1'b0, `IDX_GAIN_UPPER}:
                    gain_upper_q <= masked_write(gain_upper_q, wdata16, `MASK_GAIN_UPPER);
                {1'b0, `IDX_GAIN_LOWER}:
                    gain_lower_q <= masked_write(gain_lower_q, wdata16, `MASK_GAIN_LOWER);
                {1'b0, `IDX_INIT_TWO}:
                    init_two_q <= masked_write(init_two_q, wdata16, `MASK_INIT_TWO);
                {1'b0, `IDX_BW_PD}:
                    bw_pd_q <= masked_write(bw_pd_q, wdata16, `MASK_BW_PD);
                {1'b0, `IDX_REF_FMT}:
                    ref_fmt_q <= masked_write(ref_fmt_q, wdata16, `MASK_REF_FMT);
                {1'b0, `IDX_RANGE_LOW}:
                    range_low_q <= masked_write(range_low_q, wdata16, `MASK_RANGE);
                {1'b0, `IDX_RANGE_HIGH}:
                    range_high_q <= masked_write(range_high_q, wdata16, `MASK_RANGE);
                {1'b0, `IDX_CM_PD}:
                    cm_pd_q <= masked_write(cm_pd_q, wdata16, `MASK_CM_PD);
                {1'b0, `IDX_INIT_CM}:
                    init_cm_q <= masked_write(init_cm_q, wdata16, `MASK_INIT_CM);
                {1'b1, `IDX_BOOST_BANK2}:
                    boost_q <= masked_write(boost_q, wdata16, `MASK_BOOST_BANK2);
                default:
                    boost_q <= boost_q;
            endcase
        end
    end

    // Decoded controls, registered one cycle after the stored value
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            gain_corr_group_b             <= 22'h000000;
            channel_bandwidth_select      <= 8'h00;
            channel_powered_down          <= 8'h00;
            reference_source_select       <= 1'b0;
            lanes_two_mode                <= 1'b0;
            data_out_lane_enable_hi       <= 2'h0;
            data_out_lane_enable_lo       <= 2'h0;
            single_data_rate              <= 1'b0;
            input_range_field             <= 32'h0000_0000;
            input_range_valid             <= 8'h00;
            common_mode_range_low_group   <= 2'h0;
            common_mode_range_high_group  <= 2'h0;
            common_mode_enable_low_group  <= 1'b0;
            common_mode_enable_high_group <= 1'b0;
            full_device_powerdown         <= 1'b0;
            init_complete                 <= 1'b0;
            speed_boost_cfg_c             <= 1'b0;
            speed_boost_cfg_d             <= 1'b0;
        end
        else
        begin
            gain_corr_group_b <= gain_joined;
            // Bit 7 of this bus is channel eight
            channel_bandwidth_select <= bw_pd_q[`POS_BW_LSB+7 -: 8];
            // Chip power-down overrides the group field
            case (bw_pd_q[1:0])
                2'h0:    channel_powered_down <= {8{cm_pd_q[`POS_CHIP_PD]}};
                2'h1:    channel_powered_down <= 8'hf0 | {8{cm_pd_q[`POS_CHIP_PD]}};
                2'h2:    channel_powered_down <= 8'h0f | {8{cm_pd_q[`POS_CHIP_PD]}};
                default: channel_powered_down <= 8'hff;
            endcase
            reference_source_select <= ref_fmt_q[`POS_REF_SEL];
            lanes_two_mode          <= ref_fmt_q[`POS_LANES];
            // Lane enables: bit1 is D3 / D1, bit0 is D2 / D0
            data_out_lane_enable_hi <= ref_fmt_q[`POS_LANES] ? 2'h2 : 2'h3;
            data_out_lane_enable_lo <= ref_fmt_q[`POS_LANES] ? 2'h2 : 2'h3;
            single_data_rate        <= ref_fmt_q[`POS_RATE];
            input_range_field       <= {range_high_q, range_low_q};
            input_range_valid       <= range_ok;
            // Without the global enable every channel sits at twelve volts
            if (init_cm_q[`POS_CM_GLOBAL])
            begin
                common_mode_range_low_group   <= cm_pd_q[`POS_CM_RNG_LO+1 -: 2];
                common_mode_range_high_group  <= cm_pd_q[`POS_CM_RNG_HI+1 -: 2];
                common_mode_enable_low_group  <= cm_pd_q[`POS_CM_EN_LO];
                common_mode_enable_high_group <= cm_pd_q[`POS_CM_EN_HI];
            end
            else
            begin
                common_mode_range_low_group   <= `CM_CODE_12V;
                common_mode_range_high_group  <= `CM_CODE_12V;
                common_mode_enable_low_group  <= 1'b0;
                common_mode_enable_high_group <= 1'b0;
            end
            full_device_powerdown <= cm_pd_q[`POS_CHIP_PD];
            // Status only: converter needs all four init bits from the host
            init_complete <= init_two_q[`POS_INIT_TWO]
                & init_cm_q[`POS_INIT_THREE]
                & init_cm_q[`POS_AMP_INIT_SECOND]
                & init_cm_q[`POS_AMP_INIT_FIRST];
            speed_boost_cfg_c <= boost_q[`POS_BOOST_C];
            speed_boost_cfg_d <= boost_q[`POS_BOOST_D];
        end
    end
endmodule

/* logic/gain_code_join.v */
// Joins the two group B gain halves and checks range codes
`timescale 1ns/1ps
`include "adc_cfg_defs.vh"
module gain_code_join
(
    input  wire [15:0] upper,
    input  wire [15:0] lower,
    input  wire [15:0] range_lo,
    input  wire [15:0] range_hi,
    output wire [21:0] gain_code,
    output wire [7:0]  range_valid
);
    // Upper sixteen bits then lower six
    assign gain_code = {upper, lower[5:0]};

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : g_rng
            // Codes above 5 have no documented range
            assign range_valid[i]   = range_lo[4*i+3 -: 4] <= `RANGE_CODE_MAX;
            assign range_valid[i+4] = range_hi[4*i+3 -: 4] <= `RANGE_CODE_MAX;
        end
    endgenerate
endmodule

/* verif/adc_cfg_chk.sv */
// Concurrent checks on the configuration bank ports
`timescale 1ns/1ps
module adc_cfg_chk
(
    input wire        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
    input wire [31:0] haddr, hwdata, input_range_field,
    input wire [1:0]  htrans, data_out_lane_enable_hi, data_out_lane_enable_lo,
    input wire [1:0]  common_mode_range_low_group, common_mode_range_high_group,
    input wire        common_mode_enable_low_group, common_mode_enable_high_group,
    input wire [21:0] gain_corr_group_b,
    input wire [7:0]  channel_bandwidth_select, channel_powered_down, input_range_valid,
    input wire        reference_source_select, lanes_two_mode, single_data_rate,
    input wire        full_device_powerdown, speed_boost_cfg_c, speed_boost_cfg_d
);
    logic        wr_q, g_q, g_p;
    logic [8:0]  idx_q;
    logic [15:0] wd_q, c4_q, c4_p;
    logic [1:0]  st_q;

    function automatic logic [7:0] rng_ok(input logic [31:0] f);
        for (int i = 0; i < 8; i++)
            rng_ok[i] = f[4*i+:4] <= 4'h5;
    endfunction

    // Outputs trail the registers by one edge, so the shadow does too
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            {wr_q, g_q, g_p, idx_q, wd_q, c4_q, c4_p, st_q} <= '0;
        else
        begin
            wr_q  <= hsel && hready && htrans[1] && hwrite;
            idx_q <= haddr[10:2];
            if (wr_q)
                wd_q <= hwdata[15:0];
            if (wr_q && idx_q == 9'h0c4)
                c4_q <= hwdata[15:0];
            if (wr_q && idx_q == 9'h0c5)
                g_q <= hwdata[4];
            c4_p <= c4_q;
            g_p  <= g_q;
            if (st_q != 2'h3)
                st_q <= st_q + 2'h1;
        end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bank stalled or flagged an error");
    a_gain_split: assert property (
        wr_q && idx_q == 9'h04a |-> ##2 gain_corr_group_b[21:6] == wd_q)
        else $error("gain upper half misplaced");
    a_bw_select: assert property (
        wr_q && idx_q == 9'h0c0 |-> ##2 channel_bandwidth_select == wd_q[9:2])
        else $error("bandwidth select wrong");
    a_chan_down: assert property (
        wr_q && idx_q == 9'h0c0 |-> ##2 channel_powered_down ==
        ({{4{wd_q[0]}}, {4{wd_q[1]}}} | {8{full_device_powerdown}}))
        else $error("channel power-down wrong");
    a_out_format: assert property (
        wr_q && idx_q == 9'h0c1 |-> ##2 {reference_source_select, lanes_two_mode,
        single_data_rate} == {wd_q[11], wd_q[9], wd_q[8]})
        else $error("reference or output format wrong");
    a_lane_enable: assert property (st_q == 2'h3 |->
        data_out_lane_enable_hi == {1'b1, !lanes_two_mode} &&
        data_out_lane_enable_lo == {1'b1, !lanes_two_mode})
        else $error("lane enables disagree with lane mode");
    a_range_valid: assert property (
        st_q == 2'h3 |-> input_range_valid == rng_ok(input_range_field))
        else $error("range valid flags wrong");
    a_cm_gate: assert property (st_q == 2'h3 |->
        {common_mode_range_high_group, common_mode_range_low_group,
        common_mode_enable_high_group, common_mode_enable_low_group} ==
        (g_p ? {c4_p[9:6], c4_p[3], c4_p[2]} : 6'h28))
        else $error("common-mode gating wrong");
    a_boost_bits: assert property (
        wr_q && idx_q == 9'h125 |-> ##2
        {speed_boost_cfg_d, speed_boost_cfg_c} == {wd_q[11], wd_q[9]})
        else $error("speed-boost bits wrong");
endmodule

bind adc_config_register_bank adc_cfg_chk chk_u (.hclk, .hresetn, .hsel, .hwrite,
    .hready, .hreadyout, .hresp, .haddr, .hwdata, .input_range_field, .htrans,
    .data_out_lane_enable_hi, .data_out_lane_enable_lo, .common_mode_range_low_group,
    .common_mode_range_high_group, .common_mode_enable_low_group,
    .common_mode_enable_high_group, .gain_corr_group_b, .channel_bandwidth_select,
    .channel_powered_down, .input_range_valid, .reference_source_select, .lanes_two_mode,
    .single_data_rate, .full_device_powerdown, .speed_boost_cfg_c, .speed_boost_cfg_d);

/* verif/cfg_host_model.sv */
// Host model that programs the bank with single AHB-Lite word transfers
`timescale 1ns/1ps
module cfg_host_model
(
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial
    begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // No cycle budget here; the bench watchdog ends a hang
    task automatic xfer(input logic [8:0] idx, input logic wr, input logic [31:0] wd,
                        output logic [31:0] rdat);
        hsel   <= 1'b1;
        haddr  <= {21'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wr ? wd : ~hwdata;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        rdat = hrdata;
        // Released data must not keep looking valid
        hwdata <= ~hwdata;
    endtask

    task automatic init_seq;
        logic [31:0] unused;
        xfer(9'h092, 1'b1, 32'h2, unused);
        xfer(9'h0c5, 1'b1, 32'h604, unused);
    endtask
endmodule

/* verif/tb.sv */
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module tb;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rng;
    logic [1:0]  htrans, en_hi, en_lo, cm_lo, cm_hi;
    logic [2:0]  hsize;
    logic [21:0] gain;
    logic [7:0]  bw, pd, rng_ok;
    logic        ref_sel, two_lane, sdr, cme_lo, cme_hi, chip_pd, init_ok, bst_c, bst_d;
    integer      failures = 0;
    integer      checks = 0;
    logic [8:0]  ix [10] = '{9'h04a, 9'h04b, 9'h092, 9'h0c0, 9'h0c1,
                             9'h0c2, 9'h0c3, 9'h0c4, 9'h0c5, 9'h125};
    logic [15:0] mk [10] = '{16'hffff, 16'h003f, 16'h0002, 16'h03ff, 16'h0b00,
                             16'hffff, 16'hffff, 16'h03ff, 16'hc67c, 16'h0a00};

    cfg_host_model host_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    adc_config_register_bank dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .gain_corr_group_b(gain), .channel_bandwidth_select(bw), .channel_powered_down(pd),
        .reference_source_select(ref_sel), .lanes_two_mode(two_lane),
        .data_out_lane_enable_hi(en_hi), .data_out_lane_enable_lo(en_lo),
        .single_data_rate(sdr), .input_range_field(rng), .input_range_valid(rng_ok),
        .common_mode_range_low_group(cm_lo), .common_mode_range_high_group(cm_hi),
        .common_mode_enable_low_group(cme_lo), .common_mode_enable_high_group(cme_hi),
        .full_device_powerdown(chip_pd), .init_complete(init_ok),
        .speed_boost_cfg_c(bst_c), .speed_boost_cfg_d(bst_d));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [8:0] idx, input logic [31:0] d);
        logic [31:0] r;
        host_u.xfer(idx, 1'b1, d, r);
    endtask

    task automatic rd(input logic [8:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        host_u.xfer(idx, 1'b0, 32'h0, r);
        chk(r, exp);
    endtask

    // Decoded outputs land one edge after the register
    task automatic settle;
        repeat (2) @(posedge hclk);
        #1;
    endtask

    task automatic t_reset;
        for (int i = 0; i < 10; i++)
            rd(ix[i], 32'h0);
        chk({en_hi, en_lo}, 4'hf);
        chk({cm_hi, cm_lo, cme_hi, cme_lo}, 6'h28);
        chk({pd, init_ok}, 9'h0);
    endtask

    task automatic t_masks;
        for (int i = 0; i < 10; i++)
        begin
            wr(ix[i], 32'hffffffff);
            rd(ix[i], {16'h0, mk[i]});
            wr(ix[i], 32'h0);
        end
        wr(9'h025, 32'hffff);
        rd(9'h025, 32'h0);
        rd(9'h125, 32'h0);
    endtask

    task automatic t_gain;
        wr(9'h04a, 32'ha5c3);
        wr(9'h04b, 32'hffffffed);
        settle;
        chk(gain, {16'ha5c3, 6'h2d});
        rd(9'h04b, 32'h2d);
    endtask

    task automatic t_bw_pd;
        logic [7:0] b;
        logic [7:0] down [4] = '{8'h00, 8'hf0, 8'h0f, 8'hff};
        for (int p = 0; p < 4; p++)
        begin
            b = 8'h81 << p;
            wr(9'h0c0, {22'h0, b, p[1:0]});
            settle;
            chk(bw, b);
            chk(pd, down[p]);
        end
    endtask

    task automatic t_fmt;
        for (int f = 0; f < 8; f++)
        begin
            wr(9'h0c1, {20'h0, f[2], 1'b1, f[1:0], 8'hff});
            rd(9'h0c1, {20'h0, f[2], 1'b0, f[1:0], 8'h00});
            settle;
            chk({ref_sel, two_lane, sdr}, f[2:0]);
            chk({en_hi, en_lo}, f[1] ? 4'ha : 4'hf);
        end
    endtask

    task automatic t_range;
        wr(9'h0c2, 32'h5432);
        wr(9'h0c3, 32'h7610);
        settle;
        chk(rng, 32'h76105432);
        chk(rng_ok, 8'h3f);
    endtask

    task automatic t_cm;
        // Group power-down off, so only the chip bit can force channels down
        wr(9'h0c0, 32'h0);
        wr(9'h0c4, 32'h0108);
        settle;
        chk({cm_hi, cm_lo, cme_hi, cme_lo}, 6'h28);
        wr(9'h0c5, 32'h0010);
        settle;
        chk({cm_hi, cm_lo, cme_hi, cme_lo}, 6'h12);
        wr(9'h0c4, 32'h0084);
        settle;
        chk({cm_hi, cm_lo, cme_hi, cme_lo}, 6'h09);
        wr(9'h0c4, 32'h0001);
        settle;
        chk({chip_pd, pd}, 9'h1ff);
        wr(9'h0c4, 32'h0);
        wr(9'h0c5, 32'h0);
        settle;
        chk({chip_pd, pd}, 9'h0);
    endtask

    task automatic t_init;
        host_u.init_seq;
        settle;
        chk(init_ok, 1'b1);
        wr(9'h0c5, 32'h0404);
        settle;
        chk(init_ok, 1'b0);
        host_u.init_seq;
        wr(9'h092, 32'h0);
        settle;
        chk(init_ok, 1'b0);
    endtask

    task automatic t_boost;
        for (int b = 0; b < 4; b++)
        begin
            wr(9'h125, {20'h0, b[1], 1'b0, b[0], 9'h0});
            settle;
            chk({bst_d, bst_c}, b[1:0]);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    initial
    begin
        hresetn = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_masks;
        t_gain;
        t_bw_pd;
        t_fmt;
        t_range;
        t_cm;
        t_init;
        t_boost;
        stop_test;
    end

    // Whole run needs well under two thousand cycles
    initial
    begin
        #(8 * 20000);
        failures++;
        stop_test;
    end
endmodule
